// ===== design/acc_edge_detect.sv
`timescale 1ns/1ps
module acc_edge_detect (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic active,
  input wire logic level,
  input wire logic stable,
  input wire logic [1:0] eventType,
  output logic eventHit,
  output logic level_q
);
  function automatic logic match(input logic [1:0] sel, input logic rise, input logic fall);
    case (sel)
      acc_pkg::EVT_RISE: match = rise;
      acc_pkg::EVT_EITHER: match = rise | fall;
      default: match = fall;
    endcase
  endfunction : match

  logic rise;
  logic fall;

  // while active, level only updates once the last two sync stages agree; inactive forces it to zero
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      level_q <= 1'b0;
    end else if (!active) begin
      level_q <= 1'b0;
    end else if (stable) begin
      level_q <= level;
    end
  end

  assign rise = active && stable && level && !level_q;
  assign fall = active && stable && !level && level_q;
  assign eventHit = match(eventType, rise, fall);
endmodule : acc_edge_detect

// ===== design/acc_pkg.sv
// Behaviour
// - comparator runs only while control bit 7 is one
// - bit 6 picks external positive pin (0) or internal bandgap (1)
// - result high when non-inverting input exceeds inverting input
// - bit 5 flag sets on a transition matching selected event type
// - writing one to bit 5 clears the flag; zero leaves it
// - interrupt asserted while bit 4 is one and flag is set
// - bit 3 reads live comparator level; writes do not affect it
// - level bit forced and read as zero while comparator disabled
// - result driven on output pin only while bit 2 is one
// - bits 1:0 event: 00 fall, 01 rise, 10 fall, 11 either edge
// - comparator keeps running in wait mode when enabled beforehand
// - comparator disabled in every stop mode, never wakes from stop
// - deep stop wake resets block; light stop interrupt exit keeps state
package acc_pkg;
  localparam logic [31:0] ADDR_STATUS_CONTROL = 32'h0000_0000;
  localparam logic [31:0] ADDR_IRQ_STATUS = 32'h0000_0004;
  localparam logic [31:0] ADDR_IRQ_MASK = 32'h0000_0008;
  localparam int BIT_ON = 7;
  localparam int BIT_REF = 6;
  localparam int BIT_FLAG = 5;
  localparam int BIT_IRQ_EN = 4;
  localparam int BIT_LEVEL = 3;
  localparam int BIT_PIN_EN = 2;
  localparam logic [7:0] SC_RESET = 8'h00;
  localparam logic [7:0] SC_WRITABLE = 8'hD7;
  localparam logic [1:0] EVT_FALL0 = 2'h0;
  localparam logic [1:0] EVT_RISE = 2'h1;
  localparam logic [1:0] EVT_FALL2 = 2'h2;
  localparam logic [1:0] EVT_EITHER = 2'h3;
  localparam logic [1:0] IRQ_RESET = 2'h0;
  localparam int SYNC_STAGES = 3;

  typedef struct packed {
    logic on;
    logic refSelect;
    logic flag;
    logic irqEnable;
    logic level;
    logic pinEnable;
    logic [1:0] eventType;
  } acc_sc_type;

  typedef struct packed {
    logic stop;
    logic deepStop;
    logic wait_;
  } acc_power_type;
endpackage : acc_pkg

// ===== design/acc_sync.sv
`timescale 1ns/1ps
module acc_sync #(
  parameter int STAGES = acc_pkg::SYNC_STAGES
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic asyncIn,
  output logic syncOut,
  output logic stable
);
  logic [STAGES-1:0] chain_q;

  // first stage is read only by the second
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      chain_q <= '0;
    end else begin
      chain_q <= {chain_q[STAGES-2:0], asyncIn};
    end
  end

  assign syncOut = chain_q[STAGES-1];
  assign stable = (chain_q[STAGES-1] == chain_q[STAGES-2]);
endmodule : acc_sync

// ===== design/acc_top.sv
`timescale 1ns/1ps
module acc_top (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic analogResult,
  input wire acc_pkg::acc_power_type power,
  output logic comparatorPower,
  output logic referenceSourceSelect,
  output logic comparatorOutputPin,
  output logic comparatorOutputPinOe,
  output logic irq,
  output logic compareIrq
);
  acc_pkg::acc_sc_type sc_q;
  logic [1:0] irqStatus_q;
  logic [1:0] irqMask_q;
  logic wrPend_q;
  logic [31:0] wrAddr_q;
  logic syncLevel;
  logic syncStable;
  logic eventHit;
  logic levelNow;
  logic active;
  logic addrPhase;
  logic flagClear;
  logic [31:0] rdData_d;
  logic [1:0] irqEvents;

  // comparator idles in stop; wait keeps it running
  assign active = sc_q.on && !power.stop;
  assign comparatorPower = active;
  assign referenceSourceSelect = sc_q.refSelect;

  acc_sync #(
    .STAGES(acc_pkg::SYNC_STAGES)
  ) u_sync (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .asyncIn(analogResult),
    .syncOut(syncLevel),
    .stable(syncStable)
  );

  acc_edge_detect u_edge (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .active(active),
    .level(syncLevel),
    .stable(syncStable),
    .eventType(sc_q.eventType),
    .eventHit(eventHit),
    .level_q(levelNow)
  );

  assign addrPhase = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign flagClear = wrPend_q && (wrAddr_q == acc_pkg::ADDR_STATUS_CONTROL) &&
                     hwdata[acc_pkg::BIT_FLAG];

  always_ff @(posedge sys_clk) begin
    if (sys_rst || power.deepStop) begin
      wrPend_q <= 1'b0;
      wrAddr_q <= 32'h0000_0000;
    end else begin
      wrPend_q <= addrPhase && hwrite;
      wrAddr_q <= {haddr[31:2], 2'b00};
    end
  end

  // control fields; the flag and level bits have their own logic
  always_ff @(posedge sys_clk) begin
    if (sys_rst || power.deepStop) begin
      sc_q.on <= 1'b0;
      sc_q.refSelect <= 1'b0;
      sc_q.irqEnable <= 1'b0;
      sc_q.pinEnable <= 1'b0;
      sc_q.eventType <= acc_pkg::EVT_FALL0;
    end else if (wrPend_q && wrAddr_q == acc_pkg::ADDR_STATUS_CONTROL) begin
      sc_q.on <= hwdata[acc_pkg::BIT_ON];
      sc_q.refSelect <= hwdata[acc_pkg::BIT_REF];
      sc_q.irqEnable <= hwdata[acc_pkg::BIT_IRQ_EN];
      sc_q.pinEnable <= hwdata[acc_pkg::BIT_PIN_EN];
      sc_q.eventType <= hwdata[1:0];
    end
  end

  // set wins over a simultaneous clear
  always_ff @(posedge sys_clk) begin
    if (sys_rst || power.deepStop) begin
      sc_q.flag <= 1'b0;
    end else if (eventHit) begin
      sc_q.flag <= 1'b1;
    end else if (flagClear) begin
      sc_q.flag <= 1'b0;
    end
  end

  always_comb begin
    sc_q.level = levelNow;
  end

  assign irqEvents = {eventHit, eventHit && sc_q.eventType == acc_pkg::EVT_EITHER};

  always_ff @(posedge sys_clk) begin
    if (sys_rst || power.deepStop) begin
      irqStatus_q <= acc_pkg::IRQ_RESET;
      irqMask_q <= acc_pkg::IRQ_RESET;
    end else begin
      irqStatus_q <= irqEvents | (irqStatus_q &
        ~((wrPend_q && wrAddr_q == acc_pkg::ADDR_IRQ_STATUS) ? hwdata[1:0] : 2'b00));
      if (wrPend_q && wrAddr_q == acc_pkg::ADDR_IRQ_MASK) begin
        irqMask_q <= hwdata[1:0];
      end
    end
  end

  assign compareIrq = sc_q.irqEnable && sc_q.flag;
  assign irq = |(irqStatus_q & irqMask_q);

  always_comb begin
    rdData_d = 32'h0000_0000;
    case ({haddr[31:2], 2'b00})
      acc_pkg::ADDR_STATUS_CONTROL: rdData_d = {24'h00_0000, sc_q};
      acc_pkg::ADDR_IRQ_STATUS: rdData_d = {30'h0000_0000, irqStatus_q};
      acc_pkg::ADDR_IRQ_MASK: rdData_d = {30'h0000_0000, irqMask_q};
      default: rdData_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      hrdata <= 32'h0000_0000;
    end else if (addrPhase && !hwrite) begin
      hrdata <= rdData_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst || power.deepStop) begin
      comparatorOutputPin <= 1'b0;
      comparatorOutputPinOe <= 1'b0;
    end else begin
      comparatorOutputPin <= sc_q.pinEnable && levelNow;
      comparatorOutputPinOe <= sc_q.pinEnable;
    end
  end

  a_irq_gate: assert property (@(posedge sys_clk) disable iff (sys_rst)
    compareIrq == (sc_q.irqEnable && sc_q.flag)) else $error("irq gate wrong");
  a_level_off: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !sc_q.on |=> !levelNow) else $error("level not zero when off");
  a_flag_set: assert property (@(posedge sys_clk) disable iff (sys_rst || power.deepStop)
    eventHit |=> sc_q.flag) else $error("flag not set");
  a_flag_clear: assert property (@(posedge sys_clk) disable iff (sys_rst || power.deepStop)
    flagClear && !eventHit |=> !sc_q.flag) else $error("flag not cleared");
  a_flag_keep: assert property (@(posedge sys_clk) disable iff (sys_rst || power.deepStop)
    sc_q.flag && !flagClear |=> sc_q.flag) else $error("flag lost");
  a_stop_off: assert property (@(posedge sys_clk) disable iff (sys_rst)
    power.stop |-> !comparatorPower) else $error("active in stop");
  a_pin_off: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !sc_q.pinEnable |=> !comparatorOutputPinOe) else $error("pin driven");
  a_rise_only: assert property (@(posedge sys_clk) disable iff (sys_rst)
    sc_q.eventType == acc_pkg::EVT_RISE && eventHit |=> levelNow)
    else $error("rise event wrong");
  a_sync_depth: assert property (@(posedge sys_clk) disable iff (sys_rst)
    eventHit |-> $past(analogResult, 3) == syncLevel) else $error("unsynced edge");

  c_rise: cover property (@(posedge sys_clk) eventHit && sc_q.eventType == acc_pkg::EVT_RISE);
  c_either: cover property (@(posedge sys_clk) eventHit && sc_q.eventType == acc_pkg::EVT_EITHER);
  c_irq: cover property (@(posedge sys_clk) compareIrq);
endmodule : acc_top

// ===== tb/acc_core_model.sv
`timescale 1ns/1ps
module acc_core_model (
  input wire logic bandgapSel,
  input wire logic [7:0] posVolt,
  input wire logic [7:0] negVolt,
  input wire logic [7:0] bandgapVolt,
  output logic result
);
  logic [7:0] plusIn;
  assign plusIn = bandgapSel ? bandgapVolt : posVolt;
  // an unpowered core still shows a level here; the block has to mask it
  assign result = plusIn > negVolt;
endmodule : acc_core_model

// ===== tb/test_analog_comparator_control.sv
`timescale 1ns/1ps
module test_analog_comparator_control;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, analogResult, comparatorPower, refSel;
  logic pin, pinOe, irq, compareIrq;
  acc_pkg::acc_power_type power = '0;
  logic [7:0] posVolt = 8'h32;
  logic [7:0] negVolt = 8'h64;
  logic [7:0] bgVolt = 8'h14;
  logic [31:0] v;
  int errorCnt = 0;
  int totalChecks = 0;
  always #5 sys_clk = ~sys_clk;
  acc_top u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .analogResult(analogResult),
    .power(power), .comparatorPower(comparatorPower), .referenceSourceSelect(refSel),
    .comparatorOutputPin(pin), .comparatorOutputPinOe(pinOe), .irq(irq),
    .compareIrq(compareIrq));
  acc_core_model u_core (.bandgapSel(refSel), .posVolt(posVolt), .negVolt(negVolt),
    .bandgapVolt(bgVolt), .result(analogResult));
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      errorCnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic xfer(input logic [31:0] a, input logic w, input logic [7:0] wd);
    @(posedge sys_clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    v = hrdata;
  endtask : xfer
  task automatic complete_run;
    $display("checks %0d mismatches %0d", totalChecks, errorCnt);
    if (errorCnt == 0 && totalChecks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : complete_run
  initial begin
    #200000;
    errorCnt++;
    complete_run();
  end
  initial begin
    logic [1:0] md;
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    xfer(acc_pkg::ADDR_STATUS_CONTROL, 1'b0, 8'h00);
    chk("sc reset", v[7:0], acc_pkg::SC_RESET);
    chk("power off", 8'(comparatorPower), 8'h00);
    $display("reset test done");
    for (int m = 0; m < 4; m++) begin
      md = m[1:0];
      xfer(acc_pkg::ADDR_STATUS_CONTROL, 1'b1, {6'h28, md});
      repeat (10) @(posedge sys_clk);
      xfer(acc_pkg::ADDR_STATUS_CONTROL, 1'b1, {6'h28, md});
      posVolt <= 8'h96;
      repeat (10) @(posedge sys_clk);
      xfer(acc_pkg::ADDR_STATUS_CONTROL, 1'b0, 8'h00);
      chk("rise flag", 8'(v[5]), 8'(md[0]));
      chk("level high", 8'(v[3]), 8'h01);
      xfer(acc_pkg::ADDR_STATUS_CONTROL, 1'b1, {6'h28, md});
      posVolt <= 8'h32;
      repeat (10) @(posedge sys_clk);
      xfer(acc_pkg::ADDR_STATUS_CONTROL, 1'b0, 8'h00);
      chk("fall flag", 8'(v[5]), 8'(md != 2'h1));
      chk("level low", 8'(v[3]), 8'h00);
    end
    $display("event type test done");
    xfer(acc_pkg::ADDR_STATUS_CONTROL, 1'b1, 8'h9F);
    xfer(acc_pkg::ADDR_STATUS_CONTROL, 1'b0, 8'h00);
    chk("flag kept", v[7:0], 8'hB7);
    chk("okay resp", 8'(hresp), 8'h00);
    chk("cmp irq", 8'(compareIrq), 8'h01);
    chk("pin oe", 8'(pinOe), 8'h01);
    posVolt <= 8'h96;
    repeat (10) @(posedge sys_clk);
    chk("pin high", 8'(pin), 8'h01);
    xfer(acc_pkg::ADDR_STATUS_CONTROL, 1'b1, 8'hF9);
    repeat (10) @(posedge sys_clk);
    xfer(acc_pkg::ADDR_STATUS_CONTROL, 1'b0, 8'h00);
    chk("bandgap sel", 8'(refSel), 8'h01);
    chk("cleared", v[7:0], 8'hD1);
    chk("irq gone", 8'(compareIrq), 8'h00);
    $display("control bits test done");
    xfer(acc_pkg::ADDR_IRQ_MASK, 1'b1, 8'h02);
    bgVolt <= 8'hC8;
    repeat (10) @(posedge sys_clk);
    chk("irq set", 8'(irq), 8'h01);
    xfer(acc_pkg::ADDR_IRQ_STATUS, 1'b0, 8'h00);
    chk("irq status", 8'(v[1]), 8'h01);
    xfer(acc_pkg::ADDR_IRQ_STATUS, 1'b1, 8'h03);
    xfer(acc_pkg::ADDR_IRQ_MASK, 1'b1, 8'h00);
    bgVolt <= 8'h14;
    repeat (10) @(posedge sys_clk);
    chk("irq masked", 8'(irq), 8'h00);
    xfer(acc_pkg::ADDR_STATUS_CONTROL, 1'b1, 8'hC3);
    @(posedge sys_clk);
    chk("ie off", 8'(compareIrq), 8'h00);
    xfer(32'h0000_0010, 1'b0, 8'h00);
    chk("unmapped", v[7:0], 8'h00);
    $display("interrupt test done");
    bgVolt <= 8'hC8;
    xfer(acc_pkg::ADDR_STATUS_CONTROL, 1'b1, 8'h40);
    repeat (10) @(posedge sys_clk);
    xfer(acc_pkg::ADDR_STATUS_CONTROL, 1'b0, 8'h00);
    chk("level off", 8'(v[3]), 8'h00);
    chk("power off", 8'(comparatorPower), 8'h00);
    xfer(acc_pkg::ADDR_STATUS_CONTROL, 1'b1, 8'hC0);
    power.wait_ <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk("wait on", 8'(comparatorPower), 8'h01);
    power.stop <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk("stop off", 8'(comparatorPower), 8'h00);
    power.deepStop <= 1'b1;
    repeat (2) @(posedge sys_clk);
    power <= '0;
    xfer(acc_pkg::ADDR_STATUS_CONTROL, 1'b0, 8'h00);
    chk("deep stop", v[7:0], acc_pkg::SC_RESET);
    $display("power mode test done");
    complete_run();
  end
endmodule : test_analog_comparator_control
